//--- hdl/ued_endpoint_regs.sv
// endpoint descriptor registers with axi4-lite slave, in response logic and interrupt
`timescale 1ns/1ns
// Behaviour
// - ep1-3 y count: seven bits, 0..64
// - y count bit7 set means NAK in
// - one size field per endpoint 1-3, bit7 zero
// - endpoint 0 uses four dedicated registers
// - endpoint 0 start addresses fixed FEF0/FEF8
// - ep0 in config FF80, count FF81
// - ep0 out config FF82, count FF83
// - ep0 fields keep endpoint 1-3 positions
// - config bit2 enables completion interrupt
// - bit3 stall, cleared by next setup
// - bit5 read-only data toggle state
// - bit7 lets buffer manager serve endpoint
// - ep0 count four bits, above 8 acts 8
// - ep0 count bit7 resets set, NAK
// - base entries give A10..A3, unchanged
module ued_endpoint_regs #(
  parameter int ADDR_W = ued_pkg::ADDR_W
) (
  // clock and reset
  input  logic                       sys_clk_i,
  input  logic                       reset_n_i,
  // axi4-lite write address and data
  input  logic [ADDR_W-1:0]          s_axi_awaddr_i,
  input  logic                       s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  logic [ued_pkg::DATA_W-1:0] s_axi_wdata_i,
  input  logic [3:0]                 s_axi_wstrb_i,
  input  logic                       s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  logic                       s_axi_bready_i,
  // axi4-lite read
  input  logic [ADDR_W-1:0]          s_axi_araddr_i,
  input  logic                       s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [ued_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  logic                       s_axi_rready_i,
  // buffer manager
  input  ued_pkg::ued_bm_evt_s       bm_evt_i,
  output ued_pkg::ued_bm_resp_s      bm_resp_o,
  // interrupt
  output logic                       irq_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic                       awready;
    logic                       wready;
    logic                       aw_held;
    logic                       w_held;
    logic [ADDR_W-1:0]          awaddr;
    logic [7:0]                 wdata;
    logic                       wstrb0;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [1:0]                 rresp;
    logic [ued_pkg::DATA_W-1:0] rdata;
    logic [7:0]                 ep0_in_cfg;
    logic [7:0]                 ep0_in_cnt;
    logic [7:0]                 ep0_out_cfg;
    logic [7:0]                 ep0_out_cnt;
    logic [ued_pkg::IRQ_W-1:0]  irq_status;
    logic [ued_pkg::IRQ_W-1:0]  irq_mask;
    logic                       irq;
    ued_pkg::ued_bm_resp_s      bm_resp;
  } ued_core_s;

  ued_core_s             core;
  ued_core_s             next_core;
  ued_pkg::ued_in_desc_s desc [1:ued_pkg::NUM_EP];

  logic [15:0]           wr_idx;
  logic [15:0]           rd_idx;
  logic                  wr_fire;
  logic                  wr_en;
  logic                  rd_fire;
  logic                  done0;
  logic                  token0;
  logic [3:1]            wr_cnt;
  logic [3:1]            wr_size;
  logic [3:1]            wr_base;
  logic [3:1]            taken;

  // ==========================================================================
  // decode
  function automatic logic [1:0] ep_slot(input logic [15:0] idx, input logic [15:0] base);
    logic [15:0] off;
    off = idx - base;
    ep_slot = (off != 16'h0000 && off <= 16'h0003) ? off[1:0] : 2'h0;
  endfunction : ep_slot

  function automatic logic is_mapped(input logic [15:0] idx);
    is_mapped = (idx >= ued_pkg::IDX_EP0_IN_CFG && idx <= ued_pkg::IDX_IRQ_MASK)
             || ep_slot(idx, ued_pkg::IDX_Y_COUNT_BASE) != 2'h0
             || ep_slot(idx, ued_pkg::IDX_SIZE_BASE) != 2'h0
             || ep_slot(idx, ued_pkg::IDX_Y_ADDR_BASE) != 2'h0;
  endfunction : is_mapped

  function automatic logic [7:0] rd_value(input logic [15:0] idx);
    logic [1:0] n;
    rd_value = 8'h00;
    n        = 2'h0;
    case (idx)
      ued_pkg::IDX_EP0_IN_CFG:  rd_value = core.ep0_in_cfg;
      ued_pkg::IDX_EP0_IN_CNT:  rd_value = core.ep0_in_cnt;
      ued_pkg::IDX_EP0_OUT_CFG: rd_value = core.ep0_out_cfg;
      ued_pkg::IDX_EP0_OUT_CNT: rd_value = core.ep0_out_cnt;
      ued_pkg::IDX_IRQ_STATUS:  rd_value = {4'h0, core.irq_status};
      ued_pkg::IDX_IRQ_MASK:    rd_value = {4'h0, core.irq_mask};
      default: begin
        n = ep_slot(idx, ued_pkg::IDX_Y_COUNT_BASE);
        if (n != 2'h0) begin
          rd_value = {desc[n].nak, desc[n].count};
        end
        n = ep_slot(idx, ued_pkg::IDX_SIZE_BASE);
        if (n != 2'h0) begin
          rd_value = {1'b0, desc[n].size};
        end
        n = ep_slot(idx, ued_pkg::IDX_Y_ADDR_BASE);
        if (n != 2'h0) begin
          rd_value = desc[n].base;
        end
      end
    endcase
  endfunction : rd_value

  assign wr_idx  = core.awaddr[17:2];
  assign rd_idx  = s_axi_araddr_i[17:2];
  assign wr_fire = core.aw_held && core.w_held && !core.bvalid;
  assign wr_en   = wr_fire && core.wstrb0 && is_mapped(wr_idx);
  assign rd_fire = s_axi_arvalid_i && core.arready;
  assign done0   = bm_evt_i.in_done && bm_evt_i.done_ep == 2'h0;
  assign token0  = bm_evt_i.in_token && bm_evt_i.token_ep == 2'h0;

  // ==========================================================================
  // endpoints 1..3
  for (genvar n = 1; n <= ued_pkg::NUM_EP; n++) begin : g_ep
    assign wr_cnt[n]  = wr_en && wr_idx == ued_pkg::IDX_Y_COUNT_BASE + 16'(n);
    assign wr_size[n] = wr_en && wr_idx == ued_pkg::IDX_SIZE_BASE + 16'(n);
    assign wr_base[n] = wr_en && wr_idx == ued_pkg::IDX_Y_ADDR_BASE + 16'(n);
    assign taken[n]   = bm_evt_i.in_done && bm_evt_i.done_ep == 2'(n);

    ued_in_ep_desc u_desc (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .wr_count_i (wr_cnt[n]),
      .wr_size_i  (wr_size[n]),
      .wr_base_i  (wr_base[n]),
      .wdata_i    (core.wdata),
      .taken_i    (taken[n]),
      .desc_o     (desc[n])
    );
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_core = core;

    // bus: address and data may arrive in either order
    if (s_axi_awvalid_i && core.awready) begin
      next_core.aw_held = 1'b1;
      next_core.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && core.wready) begin
      next_core.w_held = 1'b1;
      next_core.wdata  = s_axi_wdata_i[7:0];
      next_core.wstrb0 = s_axi_wstrb_i[0];
    end
    if (core.bvalid && s_axi_bready_i) begin
      next_core.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_core.aw_held = 1'b0;
      next_core.w_held  = 1'b0;
      next_core.bvalid  = 1'b1;
      next_core.bresp   = is_mapped(wr_idx) ? ued_pkg::AXI_OKAY : ued_pkg::AXI_SLVERR;
    end
    next_core.awready = !next_core.aw_held && !next_core.bvalid;
    next_core.wready  = !next_core.w_held && !next_core.bvalid;

    if (core.rvalid && s_axi_rready_i) begin
      next_core.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_core.rvalid = 1'b1;
      next_core.rdata  = {24'h000000, rd_value(rd_idx)};
      next_core.rresp  = is_mapped(rd_idx) ? ued_pkg::AXI_OKAY : ued_pkg::AXI_SLVERR;
    end
    next_core.arready = !next_core.rvalid;

    // endpoint 0 in configuration; a same-cycle software write of stall beats setup
    if (bm_evt_i.setup) begin
      next_core.ep0_in_cfg[ued_pkg::CFG_STALL_BIT] = 1'b0;
    end
    if (wr_en && wr_idx == ued_pkg::IDX_EP0_IN_CFG) begin
      // toggle and reserved bits are not writable
      next_core.ep0_in_cfg = (core.wdata & ued_pkg::CFG_WR_MASK)
                           | (next_core.ep0_in_cfg & ~ued_pkg::CFG_WR_MASK);
    end
    if (done0) begin
      next_core.ep0_in_cfg[ued_pkg::CFG_TOGGLE_BIT] =
        ~core.ep0_in_cfg[ued_pkg::CFG_TOGGLE_BIT];
    end

    // endpoint 0 in byte count; hardware nak set wins over a clearing write
    if (wr_en && wr_idx == ued_pkg::IDX_EP0_IN_CNT) begin
      next_core.ep0_in_cnt = core.wdata & ued_pkg::CNT0_WR_MASK;
    end
    if (done0) begin
      next_core.ep0_in_cnt[ued_pkg::CNT_NAK_BIT] = 1'b1;
    end

    // endpoint 0 out pair: storage only, same field positions
    if (wr_en && wr_idx == ued_pkg::IDX_EP0_OUT_CFG) begin
      next_core.ep0_out_cfg = core.wdata & ued_pkg::CFG_WR_MASK;
    end
    if (wr_en && wr_idx == ued_pkg::IDX_EP0_OUT_CNT) begin
      next_core.ep0_out_cnt = core.wdata & ued_pkg::CNT0_WR_MASK;
    end

    // interrupts: read clears, an event in the same cycle survives
    if (rd_fire && rd_idx == ued_pkg::IDX_IRQ_STATUS) begin
      next_core.irq_status = '0;
    end
    if (done0 && core.ep0_in_cfg[ued_pkg::CFG_IRQ_EN_BIT]) begin
      next_core.irq_status[0] = 1'b1;
    end
    next_core.irq_status[3:1] = next_core.irq_status[3:1] | taken;
    if (wr_en && wr_idx == ued_pkg::IDX_IRQ_MASK) begin
      next_core.irq_mask = core.wdata[ued_pkg::IRQ_W-1:0];
    end
    next_core.irq = |(next_core.irq_status & next_core.irq_mask);

    // in token answer, one cycle after the token
    next_core.bm_resp.resp_valid = bm_evt_i.in_token;
    if (token0) begin
      next_core.bm_resp.start_addr  = ued_pkg::EP0_IN_START;
      next_core.bm_resp.data_toggle = core.ep0_in_cfg[ued_pkg::CFG_TOGGLE_BIT];
      // reserved codes above eight are sent as eight
      next_core.bm_resp.byte_count  = {3'h0, (core.ep0_in_cnt[3:0] > ued_pkg::EP0_MAX_COUNT)
                                      ? ued_pkg::EP0_MAX_COUNT : core.ep0_in_cnt[3:0]};
      if (!core.ep0_in_cfg[ued_pkg::CFG_ENABLE_BIT]) begin
        next_core.bm_resp.resp = ued_pkg::UED_RESP_NONE;
      end else if (core.ep0_in_cfg[ued_pkg::CFG_STALL_BIT]) begin
        next_core.bm_resp.resp = ued_pkg::UED_RESP_STALL;
      end else if (core.ep0_in_cnt[ued_pkg::CNT_NAK_BIT]) begin
        next_core.bm_resp.resp = ued_pkg::UED_RESP_NAK;
      end else begin
        next_core.bm_resp.resp = ued_pkg::UED_RESP_DATA;
      end
    end else if (bm_evt_i.in_token) begin
      next_core.bm_resp.start_addr  = {ued_pkg::BASE_HIGH, desc[bm_evt_i.token_ep].base,
                                       ued_pkg::BASE_PAD};
      next_core.bm_resp.byte_count  = desc[bm_evt_i.token_ep].count;
      next_core.bm_resp.data_toggle = 1'b0;
      next_core.bm_resp.resp        = desc[bm_evt_i.token_ep].nak
                                    ? ued_pkg::UED_RESP_NAK : ued_pkg::UED_RESP_DATA;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      core             <= '0;
      core.ep0_in_cfg  <= ued_pkg::CFG_RESET;
      core.ep0_out_cfg <= ued_pkg::CFG_RESET;
      core.ep0_in_cnt  <= ued_pkg::CNT0_RESET;
      core.ep0_out_cnt <= ued_pkg::CNT0_RESET;
    end else begin
      core <= next_core;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready_o = core.awready;
  assign s_axi_wready_o  = core.wready;
  assign s_axi_bresp_o   = core.bresp;
  assign s_axi_bvalid_o  = core.bvalid;
  assign s_axi_arready_o = core.arready;
  assign s_axi_rdata_o   = core.rdata;
  assign s_axi_rresp_o   = core.rresp;
  assign s_axi_rvalid_o  = core.rvalid;
  assign bm_resp_o       = core.bm_resp;
  assign irq_o           = core.irq;

  // ==========================================================================
  // checks
  AST_EP0_STALL_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    token0 && core.ep0_in_cfg[7] && core.ep0_in_cfg[3]
    |=> bm_resp_o.resp_valid && bm_resp_o.resp == ued_pkg::UED_RESP_STALL)
    else $error("stalled endpoint 0 not answered with stall");
  AST_SETUP_CLEARS_STALL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bm_evt_i.setup && !(wr_en && wr_idx == ued_pkg::IDX_EP0_IN_CFG) |=> !core.ep0_in_cfg[3])
    else $error("setup did not clear stall");
  AST_DISABLED_SILENT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    token0 && !core.ep0_in_cfg[7] |=> bm_resp_o.resp == ued_pkg::UED_RESP_NONE)
    else $error("disabled endpoint 0 was served");
  AST_COUNT_CAPPED: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    token0 |=> bm_resp_o.byte_count <= 7'h08 && bm_resp_o.start_addr == 16'hFEF8)
    else $error("endpoint 0 count above eight or wrong start");
  AST_DONE_NAK_TOGGLE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    done0 |=> core.ep0_in_cnt[7] && core.ep0_in_cfg[5] != $past(core.ep0_in_cfg[5]))
    else $error("completion did not set nak and flip toggle");
  AST_TOGGLE_STEADY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !done0 |=> $stable(core.ep0_in_cfg[5]))
    else $error("toggle moved without a completion");
  AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (core.ep0_in_cfg & 8'h53) == 8'h00 && (core.ep0_in_cnt & 8'h70) == 8'h00)
    else $error("reserved endpoint 0 bit set");
  AST_IRQ_ON_DONE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    done0 && core.ep0_in_cfg[2] && core.irq_mask[0] |=> core.irq_status[0] ##1 irq_o)
    else $error("enabled completion raised no interrupt");
  AST_NAK_AFTER_RESET: assert property (@(posedge sys_clk_i)
    !reset_n_i |=> core.ep0_in_cnt == 8'h80 && core.ep0_in_cfg == 8'h00)
    else $error("endpoint 0 reset values wrong");
  AST_EPN_NAK_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bm_evt_i.in_token && bm_evt_i.token_ep != 2'h0 && desc[bm_evt_i.token_ep].nak
    |=> bm_resp_o.resp == ued_pkg::UED_RESP_NAK)
    else $error("empty endpoint buffer not nak");

endmodule : ued_endpoint_regs

//--- inc/ued_pkg.sv
// shared constants, types and register map of the usb endpoint descriptor block
package ued_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADDR_W            = 18;
  localparam int          DATA_W            = 32;
  localparam int          NUM_EP            = 3;
  localparam logic [1:0]  AXI_OKAY          = 2'h0;
  localparam logic [1:0]  AXI_SLVERR        = 2'h2;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_EP0_IN_CFG    = 16'hFF80;
  localparam logic [15:0] IDX_EP0_IN_CNT    = 16'hFF81;
  localparam logic [15:0] IDX_EP0_OUT_CFG   = 16'hFF82;
  localparam logic [15:0] IDX_EP0_OUT_CNT   = 16'hFF83;
  localparam logic [15:0] IDX_IRQ_STATUS    = 16'hFF84;
  localparam logic [15:0] IDX_IRQ_MASK      = 16'hFF85;
  // endpoint n (1..3) sits at base + n
  localparam logic [15:0] IDX_Y_COUNT_BASE  = 16'hFF88;
  localparam logic [15:0] IDX_SIZE_BASE     = 16'hFF8C;
  localparam logic [15:0] IDX_Y_ADDR_BASE   = 16'hFF90;

  // ==========================================================================
  // field positions
  localparam int          CFG_IRQ_EN_BIT    = 2;
  localparam int          CFG_STALL_BIT     = 3;
  localparam int          CFG_TOGGLE_BIT    = 5;
  localparam int          CFG_ENABLE_BIT    = 7;
  localparam int          CNT_NAK_BIT       = 7;
  localparam int          IRQ_W             = 4;

  // ==========================================================================
  // writable masks and reset values
  localparam logic [7:0]  CFG_WR_MASK       = 8'h8C;
  localparam logic [7:0]  CFG_RD_MASK       = 8'hAC;
  localparam logic [7:0]  CNT0_WR_MASK      = 8'h8F;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam logic [7:0]  CNT0_RESET        = 8'h80;
  localparam logic [3:0]  EP0_MAX_COUNT     = 4'h8;
  localparam logic [15:0] EP0_OUT_START     = 16'hFEF0;
  localparam logic [15:0] EP0_IN_START      = 16'hFEF8;
  localparam logic [2:0]  BASE_PAD          = 3'h0;
  localparam logic [4:0]  BASE_HIGH         = 5'h00;

  // ==========================================================================
  // buffer manager carriers
  typedef enum logic [1:0] {
    UED_RESP_NONE  = 2'b00,
    UED_RESP_DATA  = 2'b01,
    UED_RESP_NAK   = 2'b10,
    UED_RESP_STALL = 2'b11
  } ued_resp_e;

  typedef struct packed {
    logic       in_token;
    logic [1:0] token_ep;
    logic       in_done;
    logic [1:0] done_ep;
    logic       setup;
  } ued_bm_evt_s;

  typedef struct packed {
    ued_resp_e   resp;
    logic        resp_valid;
    logic [15:0] start_addr;
    logic [6:0]  byte_count;
    logic        data_toggle;
  } ued_bm_resp_s;

  typedef struct packed {
    logic       nak;
    logic [6:0] count;
    logic [6:0] size;
    logic [7:0] base;
  } ued_in_desc_s;

  localparam ued_in_desc_s IN_DESC_RESET = '{nak: 1'b1, count: 7'h00, size: 7'h00, base: 8'h00};

endpackage : ued_pkg

//--- hdl/ued_in_ep_desc.sv
// descriptor storage of one input endpoint (1..3): y count, buffer size, y base
`timescale 1ns/1ns
module ued_in_ep_desc (
  // clock and reset
  input  logic                 sys_clk_i,
  input  logic                 reset_n_i,
  // register writes
  input  logic                 wr_count_i,
  input  logic                 wr_size_i,
  input  logic                 wr_base_i,
  input  logic [7:0]           wdata_i,
  // buffer manager event
  input  logic                 taken_i,
  // descriptor
  output ued_pkg::ued_in_desc_s desc_o
);

  // ==========================================================================
  // state
  ued_pkg::ued_in_desc_s desc;
  ued_pkg::ued_in_desc_s next_desc;

  always_comb begin
    next_desc = desc;
    if (wr_count_i) begin
      // counts above 64 are stored as written; software must not use them
      next_desc.nak   = wdata_i[ued_pkg::CNT_NAK_BIT];
      next_desc.count = wdata_i[6:0];
    end
    // hardware set beats a same-cycle clear by software
    if (taken_i) begin
      next_desc.nak = 1'b1;
    end
    if (wr_size_i) begin
      next_desc.size = wdata_i[6:0];
    end
    if (wr_base_i) begin
      next_desc.base = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      desc <= ued_pkg::IN_DESC_RESET;
    end else begin
      desc <= next_desc;
    end
  end

  assign desc_o = desc;

  // ==========================================================================
  // checks
  AST_EPN_NAK_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    taken_i |=> desc.nak)
    else $error("taken packet did not set nak");
  AST_EPN_BASE_KEPT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !wr_base_i |=> desc.base == $past(desc.base))
    else $error("base address changed without a write");

endmodule : ued_in_ep_desc

//--- sim/ued_bm_model.sv
// buffer manager model: raises token, done and setup events
`timescale 1ns/1ns
module ued_bm_model (
  // clock
  input  wire logic              sys_clk_i,
  // events towards the registers
  output ued_pkg::ued_bm_evt_s   evt_o
);
  initial evt_o = '0;
  // one-cycle pulse, taken by the registers at the edge that ends it
  task automatic pulse(input logic [6:0] v);
    @(posedge sys_clk_i);
    evt_o <= v;
    @(posedge sys_clk_i);
    evt_o <= '0;
  endtask : pulse
endmodule : ued_bm_model

//--- sim/test_usb_endpoint_descriptor_regs.sv
// self-checking bench of the endpoint descriptor registers
`timescale 1ns/1ns
module test_usb_endpoint_descriptor_regs;
  // ==========================================================================
  // signals
  logic                  clk, rst_n, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, irq;
  logic [17:0]           awa, ara;
  logic [31:0]           wd, ld, rdv;
  logic [1:0]            br, rr, lr, ep;
  logic [6:0]            c, s;
  logic [3:0]            ws;
  logic [7:0]            b;
  logic [15:0]           lfsr;
  ued_pkg::ued_bm_evt_s  evt;
  ued_pkg::ued_bm_resp_s bmr;
  int                    err_total, n_checks;

  ued_endpoint_regs dut_u (.sys_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdv), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .bm_evt_i(evt), .bm_resp_o(bmr), .irq_o(irq));
  ued_bm_model bm_u (.sys_clk_i(clk), .evt_o(evt));

  // ==========================================================================
  // helpers
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  function automatic ued_pkg::ued_bm_resp_s exp0(input logic [7:0] cfg, input logic [7:0] cnt);
    exp0 = '0;
    exp0.resp = cfg[3] ? ued_pkg::UED_RESP_STALL : cnt[7] ? ued_pkg::UED_RESP_NAK : ued_pkg::UED_RESP_DATA;
    exp0.resp_valid = 1'b1;
    exp0.start_addr = 16'hFEF8;
    exp0.byte_count = (cnt[3:0] > 4'h8) ? 7'h08 : {3'h0, cnt[3:0]};
    exp0.data_toggle = cfg[5];
  endfunction : exp0
  function automatic ued_pkg::ued_bm_resp_s expn(input logic n, input logic [6:0] k, input logic [7:0] a);
    expn = '0;
    expn.resp = n ? ued_pkg::UED_RESP_NAK : ued_pkg::UED_RESP_DATA;
    expn.resp_valid = 1'b1;
    expn.start_addr = {5'h00, a, 3'h0};
    expn.byte_count = k;
  endfunction : expn
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd  <= {24'h0, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awr) begin
        a = 1'b1;
        awv <= 1'b0;
      end
      if (!w && wrd) begin
        w = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    lr = br;
    bre <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] idx);
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    ld = rdv;
    lr = rr;
    rre <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    rd(idx);
    chk("rdata", ld, {24'h0, e});
    chk("rresp", 32'(lr), 32'(ued_pkg::AXI_OKAY));
  endtask : rdc
  task automatic tok(input logic [1:0] p, input ued_pkg::ued_bm_resp_s e);
    bm_u.pulse({1'b1, p, 4'h0});
    @(posedge clk);
    chk("bm_resp", 32'(bmr), 32'(e));
  endtask : tok
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
  initial begin
    {awv, wv, bre, arv, rre, rst_n} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    ws = 4'hF;
    lfsr = 16'd41311;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(16'hFF80, 8'h00);
    rdc(16'hFF81, 8'h80);
    rdc(16'hFF83, 8'h80);
    wr(16'hFF80, 8'hFF);
    rdc(16'hFF80, 8'h8C);
    wr(16'hFF81, 8'hFF);
    rdc(16'hFF81, 8'h8F);
    wr(16'hFF82, 8'hFF);
    rdc(16'hFF82, 8'h8C);
    tok(2'h0, exp0(8'h8C, 8'h8F));
    bm_u.pulse(7'h01);
    rdc(16'hFF80, 8'h84);
    wr(16'hFF85, 8'h0F);
    for (int i = 0; i < 16; i++) begin
      wr(16'hFF81, 8'(i));
      tok(2'h0, exp0(8'h84, 8'(i)));
    end
    bm_u.pulse(7'h08);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h1);
    rdc(16'hFF81, 8'h8F);
    rdc(16'hFF80, 8'hA4);
    rdc(16'hFF84, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h0);
    tok(2'h0, exp0(8'hA4, 8'h8F));
    wr(16'hFF80, 8'h00);
    bm_u.pulse(7'h40);
    @(posedge clk);
    chk("resp", 32'(bmr.resp), 32'(ued_pkg::UED_RESP_NONE));
    wr(16'hFF80, 8'h80);
    bm_u.pulse(7'h08);
    rdc(16'hFF84, 8'h00);
    for (int k = 0; k < 12; k++) begin
      lfsr = nxt(lfsr);
      ep = 2'(k % 3 + 1);
      c = 7'(lfsr[6:0] % 7'd65);
      b = lfsr[15:8];
      wr(16'hFF88 + 16'(ep), {lfsr[7], c});
      wr(16'hFF90 + 16'(ep), b);
      // sizes above 64 are undefined, so software keeps to 0..64
      s = 7'(lfsr[13:7] % 7'd65);
      wr(16'hFF8C + 16'(ep), {lfsr[14], s});
      rdc(16'hFF8C + 16'(ep), {1'b0, s});
      tok(ep, expn(lfsr[7], c, b));
      bm_u.pulse({4'h1, ep, 1'b0});
      rdc(16'hFF88 + 16'(ep), {1'b1, c});
      rdc(16'hFF90 + 16'(ep), b);
      rdc(16'hFF84, 8'(4'h1 << ep));
    end
    // lane 0 strobe low: write is answered but must leave the count alone
    ws <= 4'hE;
    wr(16'hFF81, 8'h00);
    chk("bresp", 32'(lr), 32'(ued_pkg::AXI_OKAY));
    rdc(16'hFF81, 8'h8F);
    wr(16'hFF88, 8'hFF);
    chk("bresp", 32'(lr), 32'(ued_pkg::AXI_SLVERR));
    rd(16'hFF88);
    chk("rresp", 32'(lr), 32'(ued_pkg::AXI_SLVERR));
    stop_test();
  end
endmodule : test_usb_endpoint_descriptor_regs
